// ===== logic/dcs_pkg.sv
// package: register map, field layout, reset values and carriers of the size/progress block
package dcs_pkg;

    // widths
    localparam int LEN_W  = 16;   // size and pointer fields
    localparam int CNT_W  = 17;   // byte counts, wide enough for 65,536
    localparam int ADDR_W = 8;    // register port address
    localparam int EVT_W  = 5;    // event flags

    // register offsets (byte addresses, one word each)
    localparam logic [ADDR_W-1:0] REG_SRC_LEN  = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DST_LEN  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SRC_PROG = 8'h08;
    localparam logic [ADDR_W-1:0] REG_DST_PROG = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h10;
    localparam logic [ADDR_W-1:0] REG_MASK     = 8'h14;
    localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h18;

    // values after reset
    localparam logic [LEN_W-1:0] LEN_RST    = 16'h0000;
    localparam logic [LEN_W-1:0] PTR_RST    = 16'h0000;
    localparam logic [EVT_W-1:0] EVT_RST    = 5'h00;
    localparam logic [7:0]       PAT_RST    = 8'h00;
    localparam logic [31:0]      RDATA_RST  = 32'h0000_0000;

    // an all-zero size field stands for this many bytes
    localparam logic [CNT_W-1:0] LEN_ZERO_BYTES = 17'h10000;

    // event bit positions in status and mask
    localparam int EVT_SRC_DONE = 0;
    localparam int EVT_SRC_HALF = 1;
    localparam int EVT_DST_DONE = 2;
    localparam int EVT_DST_HALF = 3;
    localparam int EVT_BLOCK    = 4;

    // control register fields
    localparam int CTRL_MODE_BIT = 0;   // pattern-match mode
    localparam int CTRL_PAT_LSB  = 8;   // pattern byte, bits 15:8

    // register port request
    typedef struct packed {
        logic              we;
        logic              re;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } dcs_bus_s;

    // one transfer reported by the channel engine
    typedef struct packed {
        logic             valid;
        logic [CNT_W-1:0] src_bytes;
        logic [CNT_W-1:0] dst_bytes;
        logic [7:0]       data;
    } dcs_xfer_s;

    // state of the top module, all but its reset synchroniser
    typedef struct packed {
        logic [LEN_W-1:0] src_len;
        logic [LEN_W-1:0] dst_len;
        logic [LEN_W-1:0] src_ptr;
        logic [LEN_W-1:0] dst_ptr;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic             pat_mode;
        logic [7:0]       pat_byte;
        logic [31:0]      rdata;
        logic             irq;
    } dcs_state_s;

endpackage

// ===== logic/dcs_progress.sv
// module: one progress pointer step with wrap, end and midpoint detection
module dcs_progress (
    // current pointer and programmed size
    input  wire logic [dcs_pkg::LEN_W-1:0] ptr,
    input  wire logic [dcs_pkg::LEN_W-1:0] len,
    // bytes moved this cycle, zero when idle
    input  wire logic [dcs_pkg::CNT_W-1:0] step,
    // results
    output logic      [dcs_pkg::LEN_W-1:0] next_ptr,
    output logic      [dcs_pkg::CNT_W-1:0] len_bytes,
    output logic                           done,
    output logic                           half
);
    logic [dcs_pkg::CNT_W:0]   sum;       // one bit spare so nothing overflows
    logic [dcs_pkg::CNT_W-1:0] half_mark; // midpoint in bytes

    // pure combinational step; the caller holds the pointer register
    always_comb begin
        // zero size stands for the full 65,536 bytes
        len_bytes = (len == dcs_pkg::LEN_RST) ? dcs_pkg::LEN_ZERO_BYTES
                                              : {1'b0, len};
        half_mark = len_bytes >> 1;
        sum       = {2'b00, ptr} + {1'b0, step};
        // end reached when the step lands on or beyond the size
        done      = (step != '0) && (sum >= {1'b0, len_bytes});
        // midpoint crossed by this step; a 1-byte block has none
        half      = (half_mark != '0) && ({1'b0, ptr} < half_mark)
                    && (sum >= {1'b0, half_mark});
        // wrap to zero at the end, else advance
        next_ptr  = done ? dcs_pkg::PTR_RST : sum[dcs_pkg::LEN_W-1:0];
    end

endmodule

// ===== logic/dcs_size_pointer_regs.sv
// module: per-channel size registers, progress pointers and their event flags

// Operation
// - writable source size, zero means 65,536 bytes
// - writable destination size, zero means 65,536 bytes
// - bits 31 to 16 read zero
// - read-only source pointer, byte index reached
// - read-only destination pointer, byte index reached
// - pattern match clears source pointer
// - all fields zero after reset
// - source done when pointer reaches size
// - source half when pointer reaches midpoint
// - destination done and half likewise
// - block complete after larger size, or match
module dcs_size_pointer_regs (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            arst_n,
    // register port
    input  wire dcs_pkg::dcs_bus_s               bus,
    output logic      [31:0]                     rdata,
    // transfers reported by the channel engine
    input  wire dcs_pkg::dcs_xfer_s              xfer,
    // progress seen by the engine
    output logic      [dcs_pkg::LEN_W-1:0]       src_progress,
    output logic      [dcs_pkg::LEN_W-1:0]       dst_progress,
    // interrupt
    output logic                                 irq
);

    // reset synchroniser: asserts at once, releases after two edges
    logic                      rst_meta;     // first stage, read only by rst_n
    logic                      rst_n;        // reset used by the whole block

    // state
    dcs_pkg::dcs_state_s       st;           // registered state
    dcs_pkg::dcs_state_s       next_st;      // next value

    // register port decode
    logic                      wr_src_len;   // write to source size
    logic                      wr_dst_len;   // write to destination size
    logic                      wr_status;    // write-one-to-clear of status
    logic                      wr_mask;      // write of mask
    logic                      wr_ctrl;      // write of control

    // pointer step results
    logic [dcs_pkg::LEN_W-1:0] src_next;     // source pointer after this step
    logic [dcs_pkg::LEN_W-1:0] dst_next;     // destination pointer after this step
    logic [dcs_pkg::CNT_W-1:0] src_bytes;    // source size in bytes
    logic [dcs_pkg::CNT_W-1:0] dst_bytes;    // destination size in bytes
    logic                      src_done;     // source end reached
    logic                      src_half;     // source midpoint reached
    logic                      dst_done;     // destination end reached
    logic                      dst_half;     // destination midpoint reached
    logic [dcs_pkg::CNT_W-1:0] src_step;     // source bytes, zero when idle
    logic [dcs_pkg::CNT_W-1:0] dst_step;     // destination bytes, zero when idle

    // events
    logic                      pat_hit;      // pattern seen in pattern mode
    logic                      src_larger;   // source is the longer side
    logic [dcs_pkg::EVT_W-1:0] evt;          // events of this cycle

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // address decode; strobes are single-cycle from the master
    assign wr_src_len = bus.we && (bus.addr == dcs_pkg::REG_SRC_LEN);
    assign wr_dst_len = bus.we && (bus.addr == dcs_pkg::REG_DST_LEN);
    assign wr_status  = bus.we && (bus.addr == dcs_pkg::REG_STATUS);
    assign wr_mask    = bus.we && (bus.addr == dcs_pkg::REG_MASK);
    assign wr_ctrl    = bus.we && (bus.addr == dcs_pkg::REG_CTRL);

    // idle cycles step by zero so no event can fire
    assign src_step = xfer.valid ? xfer.src_bytes : '0;
    assign dst_step = xfer.valid ? xfer.dst_bytes : '0;

    // source side pointer arithmetic
    dcs_progress u_src (
        .ptr       (st.src_ptr),
        .len       (st.src_len),
        .step      (src_step),
        .next_ptr  (src_next),
        .len_bytes (src_bytes),
        .done      (src_done),
        .half      (src_half)
    );

    // destination side pointer arithmetic
    dcs_progress u_dst (
        .ptr       (st.dst_ptr),
        .len       (st.dst_len),
        .step      (dst_step),
        .next_ptr  (dst_next),
        .len_bytes (dst_bytes),
        .done      (dst_done),
        .half      (dst_half)
    );

    // pattern compare against the byte just moved
    assign pat_hit = xfer.valid && st.pat_mode && (xfer.data == st.pat_byte);

    // the block ends when the longer side finishes; equal sizes take source
    assign src_larger = (src_bytes >= dst_bytes);

    // gather this cycle's events
    always_comb begin
        evt                        = '0;
        evt[dcs_pkg::EVT_SRC_DONE] = src_done;
        evt[dcs_pkg::EVT_SRC_HALF] = src_half;
        evt[dcs_pkg::EVT_DST_DONE] = dst_done;
        evt[dcs_pkg::EVT_DST_HALF] = dst_half;
        evt[dcs_pkg::EVT_BLOCK]    = pat_hit
                                     || (src_larger ? src_done : dst_done);
    end

    // next state: registers, pointers, flags, read data, interrupt
    always_comb begin
        next_st = st;

        // size fields take the low half; the upper half is dropped
        if (wr_src_len) begin
            next_st.src_len = bus.wdata[dcs_pkg::LEN_W-1:0];
        end
        if (wr_dst_len) begin
            next_st.dst_len = bus.wdata[dcs_pkg::LEN_W-1:0];
        end

        // pointers move only with transfers; bus writes never touch them
        if (pat_hit) begin
            next_st.src_ptr = dcs_pkg::PTR_RST;
        end else begin
            next_st.src_ptr = src_next;
        end
        next_st.dst_ptr = dst_next;

        // mask and control
        if (wr_mask) begin
            next_st.mask = bus.wdata[dcs_pkg::EVT_W-1:0];
        end
        if (wr_ctrl) begin
            next_st.pat_mode = bus.wdata[dcs_pkg::CTRL_MODE_BIT];
            next_st.pat_byte = bus.wdata[dcs_pkg::CTRL_PAT_LSB +: 8];
        end

        // write-one-to-clear; a new event in the same cycle wins
        if (wr_status) begin
            next_st.status = st.status & ~bus.wdata[dcs_pkg::EVT_W-1:0];
        end
        next_st.status = next_st.status | evt;

        // read data stands only in the cycle after the strobe
        next_st.rdata = dcs_pkg::RDATA_RST;
        if (bus.re) begin
            case (bus.addr)
                dcs_pkg::REG_SRC_LEN:  next_st.rdata = {16'h0000, st.src_len};
                dcs_pkg::REG_DST_LEN:  next_st.rdata = {16'h0000, st.dst_len};
                dcs_pkg::REG_SRC_PROG: next_st.rdata = {16'h0000, st.src_ptr};
                dcs_pkg::REG_DST_PROG: next_st.rdata = {16'h0000, st.dst_ptr};
                dcs_pkg::REG_STATUS:   next_st.rdata = {27'h0000000, st.status};
                dcs_pkg::REG_MASK:     next_st.rdata = {27'h0000000, st.mask};
                dcs_pkg::REG_CTRL: begin
                    next_st.rdata = {16'h0000, st.pat_byte, 7'h00, st.pat_mode};
                end
                // unmapped addresses read as zero
                default:               next_st.rdata = dcs_pkg::RDATA_RST;
            endcase
        end

        // level interrupt, registered from the next flags and mask so it lines up with status
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // state register; every field clears at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.src_len  <= dcs_pkg::LEN_RST;
            st.dst_len  <= dcs_pkg::LEN_RST;
            st.src_ptr  <= dcs_pkg::PTR_RST;
            st.dst_ptr  <= dcs_pkg::PTR_RST;
            st.status   <= dcs_pkg::EVT_RST;
            st.mask     <= dcs_pkg::EVT_RST;
            st.pat_mode <= 1'b0;
            st.pat_byte <= dcs_pkg::PAT_RST;
            st.rdata    <= dcs_pkg::RDATA_RST;
            st.irq      <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flip-flops
    assign rdata        = st.rdata;
    assign src_progress = st.src_ptr;
    assign dst_progress = st.dst_ptr;
    assign irq          = st.irq;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // a write strobe to one address
    sequence s_write(logic [dcs_pkg::ADDR_W-1:0] a);
        bus.we && (bus.addr == a);
    endsequence

    // a read strobe to one of the four size/pointer words
    sequence s_read_word;
        bus.re && (bus.addr <= dcs_pkg::REG_DST_PROG) && (bus.addr[1:0] == 2'b00);
    endsequence

    // a transfer that carries no pattern match
    sequence s_plain_xfer;
        xfer.valid && !pat_hit;
    endsequence

    // source size takes the written low half
    property p_src_len_write;
        s_write(dcs_pkg::REG_SRC_LEN) |=> (st.src_len == $past(bus.wdata[15:0]));
    endproperty
    a_src_len_write: assert property (p_src_len_write)
        else $error("source size not taken from write");

    // destination size takes the written low half and reads back
    property p_dst_len_rw;
        s_write(dcs_pkg::REG_DST_LEN) ##1 (bus.re && bus.addr == dcs_pkg::REG_DST_LEN)
        |=> (rdata == {16'h0000, $past(bus.wdata[15:0], 2)});
    endproperty
    a_dst_len_rw: assert property (p_dst_len_rw)
        else $error("destination size does not read back");

    // upper half of every size and pointer word reads zero
    property p_upper_zero;
        s_read_word |=> (rdata[31:16] == 16'h0000);
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper half of word not zero");

    // source pointer ignores bus writes and holds without transfers
    property p_src_ro;
        (!xfer.valid) |=> $stable(st.src_ptr);
    endproperty
    a_src_ro: assert property (p_src_ro)
        else $error("source pointer moved without transfer");

    // destination pointer reads back its own value
    property p_dst_read;
        (bus.re && bus.addr == dcs_pkg::REG_DST_PROG)
        |=> (rdata[15:0] == $past(st.dst_ptr));
    endproperty
    a_dst_read: assert property (p_dst_read)
        else $error("destination pointer read mismatch");

    // a pattern match zeroes the source pointer and flags block end
    property p_pattern_clear;
        pat_hit |=> (st.src_ptr == 16'h0000) && st.status[dcs_pkg::EVT_BLOCK];
    endproperty
    a_pattern_clear: assert property (p_pattern_clear)
        else $error("pattern match did not clear source pointer");

    // the first edge after release still shows reset values
    property p_reset_zero;
        $rose(rst_n) |-> (st.src_len == 16'h0000) && (st.dst_len == 16'h0000)
                         && (st.src_ptr == 16'h0000) && (st.dst_ptr == 16'h0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("fields not zero after reset");

    // reaching the source size raises the flag and wraps the pointer
    property p_src_done;
        s_plain_xfer ##0 (({1'b0, st.src_ptr} + {1'b0, xfer.src_bytes} >= {1'b0, src_bytes})
                          && (xfer.src_bytes != '0))
        |=> st.status[dcs_pkg::EVT_SRC_DONE] && (st.src_ptr == 16'h0000);
    endproperty
    a_src_done: assert property (p_src_done)
        else $error("source end not flagged or not wrapped");

    // crossing the source midpoint raises the half flag
    property p_src_half;
        (xfer.valid && ({1'b0, st.src_ptr} < (src_bytes >> 1))
         && ({1'b0, st.src_ptr} + {1'b0, xfer.src_bytes} >= {1'b0, src_bytes >> 1})
         && (src_bytes > 17'h00001))
        |=> st.status[dcs_pkg::EVT_SRC_HALF];
    endproperty
    a_src_half: assert property (p_src_half)
        else $error("source midpoint not flagged");

    // destination end flags and wraps; below the end it advances
    property p_dst_step;
        (xfer.valid && xfer.dst_bytes != '0)
        |=> (st.status[dcs_pkg::EVT_DST_DONE] && st.dst_ptr == 16'h0000)
            || (st.dst_ptr == $past(st.dst_ptr) + $past(xfer.dst_bytes[15:0]));
    endproperty
    a_dst_step: assert property (p_dst_step)
        else $error("destination pointer step wrong");

    // block end follows the longer side's end
    property p_block_end;
        (src_larger ? src_done : dst_done) |=> st.status[dcs_pkg::EVT_BLOCK];
    endproperty
    a_block_end: assert property (p_block_end)
        else $error("block end not flagged");

    // interrupt matches flags and mask in the same cycle
    property p_irq;
        ##1 (irq == |(st.status & st.mask));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not match flags and mask");

    // read data falls back to zero when no read was made
    property p_rdata_idle;
        !bus.re |=> (rdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without read strobe");

    // destination pointer holds without transfers, whatever the bus writes
    property p_dst_ro;
        (!xfer.valid) |=> $stable(st.dst_ptr);
    endproperty
    a_dst_ro: assert property (p_dst_ro)
        else $error("destination pointer moved without transfer");

    // crossing the destination midpoint raises the half flag
    property p_dst_half;
        (xfer.valid && ({1'b0, st.dst_ptr} < (dst_bytes >> 1))
         && ({1'b0, st.dst_ptr} + {1'b0, xfer.dst_bytes} >= {1'b0, dst_bytes >> 1})
         && (dst_bytes > 17'h00001))
        |=> st.status[dcs_pkg::EVT_DST_HALF];
    endproperty
    a_dst_half: assert property (p_dst_half)
        else $error("destination midpoint not flagged");

    // a flag raised while software clears it stays set
    property p_set_wins;
        (wr_status && bus.wdata[dcs_pkg::EVT_SRC_DONE] && src_done)
        |=> st.status[dcs_pkg::EVT_SRC_DONE];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("source done lost to a same-cycle clear");

endmodule

// ===== verification/tb_dcs_size_pointer_regs.sv
// testbench: register access, progress pointers, events and interrupt of the size block
module tb_dcs_size_pointer_regs;
    timeunit 1ns;
    timeprecision 100ps;

    // clock, reset and design ports
    logic                           clk;
    logic                           arst_n;
    dcs_pkg::dcs_bus_s              bus;
    logic      [31:0]               rdata;
    dcs_pkg::dcs_xfer_s             xfer;
    logic      [dcs_pkg::LEN_W-1:0] src_progress;
    logic      [dcs_pkg::LEN_W-1:0] dst_progress;
    logic                           irq;
    // bookkeeping
    int                             n_mismatch;
    int                             num_checks;

    dcs_size_pointer_regs u_dut (
        .clk          (clk),
        .arst_n       (arst_n),
        .bus          (bus),
        .rdata        (rdata),
        .xfer         (xfer),
        .src_progress (src_progress),
        .dst_progress (dst_progress),
        .irq          (irq)
    );

    // 25 MHz clock
    always #20 clk = ~clk;

    // compare one value; four-state so an unknown never matches
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [dcs_pkg::ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '{we: 1'b0, re: 1'b0, addr: a, wdata: 32'h0000_0000};
    endtask

    // write then read of one word on back-to-back strobes
    task automatic wrrd(input logic [dcs_pkg::ADDR_W-1:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input string nm);
        @(posedge clk);
        bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk);
        bus <= '{we: 1'b0, re: 1'b0, addr: a, wdata: 32'h0000_0000};
        #1;
        chk(nm, exp, rdata);
    endtask

    // one-cycle read strobe, data looked at in the single cycle it stands
    task automatic rd(input logic [dcs_pkg::ADDR_W-1:0] a, input logic [31:0] exp,
                      input string nm);
        @(posedge clk);
        bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk);
        bus <= '{we: 1'b0, re: 1'b0, addr: a, wdata: 32'h0000_0000};
        #1;
        chk(nm, exp, rdata);
    endtask

    // one transfer; held so that calls may follow back to back
    task automatic xf(input logic [16:0] s, input logic [16:0] d, input logic [7:0] dat);
        @(posedge clk);
        xfer <= '{valid: 1'b1, src_bytes: s, dst_bytes: d, data: dat};
    endtask

    // end of a burst of transfers, pointers settled afterwards
    task automatic xidle;
        @(posedge clk);
        xfer <= '{valid: 1'b0, src_bytes: 17'h00000, dst_bytes: 17'h00000, data: 8'h00};
        #1;
    endtask

    // both pointers at the ports and through the register port
    task automatic ptrs(input logic [15:0] s, input logic [15:0] d);
        chk("src_progress", {16'h0000, s}, {16'h0000, src_progress});
        chk("dst_progress", {16'h0000, d}, {16'h0000, dst_progress});
        rd(dcs_pkg::REG_SRC_PROG, {16'h0000, s}, "source progress word");
        rd(dcs_pkg::REG_DST_PROG, {16'h0000, d}, "destination progress word");
    endtask

    // verdict, the single end of the run
    task automatic wrap_up;
        $display("counts: %0d checks, %0d mismatches", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // guard against a hang: far above the length of the main sequence
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        $display("CHECK FAILED run length expected end seen limit");
        wrap_up();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        bus = '{we: 1'b0, re: 1'b0, addr: 8'h00, wdata: 32'h0000_0000};
        xfer = '{valid: 1'b0, src_bytes: 17'h00000, dst_bytes: 17'h00000, data: 8'h00};
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        // internal reset leaves through two flops; keep clear of it
        repeat (3) @(posedge clk);

        // reset values, unmapped address, read data lasting one cycle
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), 32'h0000_0000, "reset value");
        end
        @(posedge clk);
        #1;
        chk("rdata after answer", 32'h0000_0000, rdata);
        chk("irq after reset", 32'h0000_0000, {31'h0, irq});
        $display("test reset values done");

        // size fields keep 15:0 only; progress words ignore writes
        wr(dcs_pkg::REG_SRC_LEN, 32'hFFFF_2345);
        rd(dcs_pkg::REG_SRC_LEN, 32'h0000_2345, "source length");
        wrrd(dcs_pkg::REG_DST_LEN, 32'hABCD_0001, 32'h0000_0001,
             "destination length");
        wr(dcs_pkg::REG_SRC_PROG, 32'hFFFF_FFFF);
        wr(dcs_pkg::REG_DST_PROG, 32'hFFFF_FFFF);
        ptrs(16'h0000, 16'h0000);
        $display("test size fields done");

        // source 4 bytes, destination zero meaning 65,536: destination is larger
        wr(dcs_pkg::REG_SRC_LEN, 32'h0000_0004);
        wr(dcs_pkg::REG_DST_LEN, 32'h0000_0000);
        xf(17'h00002, 17'h08000, 8'h00);
        xidle();
        ptrs(16'h0002, 16'h8000);
        rd(dcs_pkg::REG_STATUS, 32'h0000_000A, "status at midpoints");
        xf(17'h00001, 17'h04000, 8'h00);
        xf(17'h00001, 17'h04000, 8'h00);
        xidle();
        ptrs(16'h0000, 16'h0000);
        rd(dcs_pkg::REG_STATUS, 32'h0000_001F, "status at ends");
        $display("test destination larger done");

        // interrupt: masked, unmasked, cleared by writing one
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        wr(dcs_pkg::REG_MASK, 32'h0000_0004);
        repeat (2) @(posedge clk);
        #1;
        chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
        rd(dcs_pkg::REG_MASK, 32'h0000_0004, "mask");
        wr(dcs_pkg::REG_STATUS, 32'h0000_0004);
        repeat (2) @(posedge clk);
        #1;
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        rd(dcs_pkg::REG_STATUS, 32'h0000_001B, "status after one clear");
        wr(dcs_pkg::REG_STATUS, 32'h0000_001F);
        rd(dcs_pkg::REG_STATUS, 32'h0000_0000, "status cleared");
        $display("test interrupt done");

        // source zero meaning 65,536, destination 4: the smaller side fires no block
        wr(dcs_pkg::REG_SRC_LEN, 32'h0000_0000);
        wr(dcs_pkg::REG_DST_LEN, 32'h0000_0004);
        xf(17'h00001, 17'h00004, 8'h00);
        xidle();
        ptrs(16'h0001, 16'h0000);
        rd(dcs_pkg::REG_STATUS, 32'h0000_000C, "status smaller side done");
        xf(17'h0FFFF, 17'h00000, 8'h00);
        xidle();
        ptrs(16'h0000, 16'h0000);
        rd(dcs_pkg::REG_STATUS, 32'h0000_001F, "status larger side done");
        wr(dcs_pkg::REG_STATUS, 32'h0000_001F);
        $display("test source larger done");

        // pattern mode: a matching byte clears the source pointer and ends the block
        wr(dcs_pkg::REG_SRC_LEN, 32'h0000_0010);
        wr(dcs_pkg::REG_DST_LEN, 32'h0000_0010);
        wr(dcs_pkg::REG_CTRL, 32'h0000_5A01);
        rd(dcs_pkg::REG_CTRL, 32'h0000_5A01, "control");
        xf(17'h00003, 17'h00003, 8'h11);
        xf(17'h00003, 17'h00003, 8'h5A);
        xidle();
        ptrs(16'h0000, 16'h0006);
        rd(dcs_pkg::REG_STATUS, 32'h0000_0010, "status on match");
        wr(dcs_pkg::REG_STATUS, 32'h0000_001F);
        // same byte with the mode off is plain data
        wr(dcs_pkg::REG_CTRL, 32'h0000_5A00);
        xf(17'h00001, 17'h00001, 8'h5A);
        xidle();
        ptrs(16'h0001, 16'h0007);
        rd(dcs_pkg::REG_STATUS, 32'h0000_0000, "status no match");
        $display("test pattern mode done");

        // an event wins over a clear of its flag in the same cycle
        fork
            wr(dcs_pkg::REG_STATUS, 32'h0000_001F);
            begin
                xf(17'h0000F, 17'h00001, 8'h00);
                xidle();
            end
        join
        ptrs(16'h0000, 16'h0008);
        rd(dcs_pkg::REG_STATUS, 32'h0000_001B, "status set beside clear");
        $display("test set beside clear done");

        // a reset in mid-run brings every field back to zero
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), 32'h0000_0000, "value after second reset");
        end
        ptrs(16'h0000, 16'h0000);
        $display("test mid-run reset done");

        wrap_up();
    end
endmodule
